// ===== design/src_capture.sv
// Response capture, index and CRC checking, response store and registers
//
// Design decision made here: register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
//
// Contract
// - Data-present bit set only for data commands
// - Index check flags mismatch when enabled
// - CRC check flags failure when enabled
// - Two-bit response type selects length/busy
// - Busy type monitors busy after response
// - Four response words at 010h-01Ch
// - Short response bits 39:8 to word0
// - Auto stop response into bits 127:96
// - Long response bits 127:8 to 119:0
// - CRC covers 47:8 or 127:8
// - Auto count response high, errors separate
// - Concurrent no-data response into bits 31:0
// - Unwritten store bits stay unchanged
// - Index or CRC error raises interrupt
module src_capture
  import src_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Card link
  input wire logic sdClk,
  input wire logic sdCmdIn,
  input wire logic sdDat0In,
  // Outputs toward command engine
  output logic dataPresent,
  output logic busyActive,
  output logic irq
);
  // Receiver states: idle, waiting for start bit, shifting, busy
  typedef enum {IDLE, WAITSTART, SHIFT, BUSY} src_state_e;

  // Link pins handled by the synchroniser loop
  localparam int NSYNC = 3;
  localparam int PIN_CLK = 0;
  localparam int PIN_CMD = 1;
  localparam int PIN_DAT0 = 2;

  // Raw link pins gathered for the loop below
  wire logic [NSYNC-1:0] pinRaw = {sdDat0In, sdCmdIn, sdClk};
  wire logic [NSYNC-1:0] pinSync;

  // Two flip-flops per pin; only the second stage is read by logic
  // Reset to the idle levels so no false edge follows reset
  generate
    for (genvar g = 0; g < NSYNC; g++)
    begin : g_sync
      logic meta_reg;
      logic sync_reg;
      always_ff @(posedge clk_sys or posedge rst)
      begin
        if (rst)
        begin
          meta_reg <= PIN_IDLE[g];
          sync_reg <= PIN_IDLE[g];
        end
        else
        begin
          meta_reg <= pinRaw[g];
          sync_reg <= meta_reg;
        end
      end
      assign pinSync[g] = sync_reg;
    end
  endgenerate

  // Delayed clock level for rise detection
  logic clkPrev_reg;
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      clkPrev_reg <= PIN_IDLE[PIN_CLK];
    else
      clkPrev_reg <= pinSync[PIN_CLK];
  end

  // Synchronised link signals; command and data lag the clock equally,
  // so the bit seen at a rise is the one the card set up before it
  wire logic sdRise = pinSync[PIN_CLK] & ~clkPrev_reg;
  wire logic cmdBit = pinSync[PIN_CMD];
  wire logic dat0Bit = pinSync[PIN_DAT0];

  // Register state
  logic [15:0] ctl_reg;
  logic [127:0] store_reg;
  logic [ST_W-1:0] stat_reg;
  logic [ST_W-1:0] mask_reg;
  logic [5:0] expIdx_reg;
  logic autoSlot_reg;
  logic [31:0] rdat_reg;
  logic ack_reg;

  // Bus decode; a request is taken only while ack is low
  wire logic busReq = wb_cyc_i & wb_stb_i & ~ack_reg;
  wire logic wrReq = busReq & wb_we_i;
  wire logic rdReq = busReq & ~wb_we_i;
  // Address hits for the registers with side effects
  wire logic hitCtl = wb_adr_i == OFF_CMD_CTRL;
  wire logic hitMask = wb_adr_i == OFF_ERR_MASK;
  wire logic hitStat = wb_adr_i == OFF_ERR_STAT;
  wire logic hitIssue = wb_adr_i == OFF_ISSUE;
  // Byte lanes widened to a bit mask
  wire logic [31:0] selMask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
    {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  // Response type and issue strobe
  wire logic [1:0] rspType = ctl_reg[1:0];
  wire logic issueStart = wrReq & hitIssue & wb_sel_i[0];

  // Read mux; unmapped addresses read zero
  // Registers narrower than the bus read zero in the upper bits
  wire logic [31:0] rdMux =
    hitCtl ? {16'h0000, ctl_reg} :
    (wb_adr_i == OFF_RESP0) ? store_reg[31:0] :
    (wb_adr_i == OFF_RESP1) ? store_reg[63:32] :
    (wb_adr_i == OFF_RESP2) ? store_reg[95:64] :
    (wb_adr_i == OFF_RESP3) ? store_reg[127:96] :
    hitStat ? {27'h0, stat_reg} :
    hitMask ? {27'h0, mask_reg} :
    hitIssue ? {23'h0, autoSlot_reg, 2'h0, expIdx_reg} : 32'h0000_0000;

  // Ack one cycle after the taking edge; busReq stays low while ack
  // stands, so each request gets exactly one pulse
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      ack_reg <= 1'b0;
    else
      ack_reg <= busReq;
  end

  // Read data captured at the taking edge, valid with the ack
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      rdat_reg <= 32'h0000_0000;
    else if (rdReq)
      rdat_reg <= rdMux;
  end
  // Outputs come straight from the flops
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;

  // Control register; the reserved bit is never stored, so it reads 0
  wire logic [15:0] ctl_next = (ctl_reg & ~selMask[15:0]) |
    (wb_dat_i[15:0] & selMask[15:0] & CTL_WRITE_MASK);
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      ctl_reg <= CTL_RESET;
    else if (wrReq & hitCtl)
      ctl_reg <= ctl_next;
  end

  // Interrupt mask; only the low byte lane carries bits
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      mask_reg <= '0;
    else if (wrReq & hitMask & wb_sel_i[0])
      mask_reg <= wb_dat_i[ST_W-1:0];
  end

  // Expected index and slot, latched by every issue write with byte lane 0; a write
  // while a frame is in flight changes the compare of that frame
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      expIdx_reg <= 6'h00;
      autoSlot_reg <= 1'b0;
    end
    else if (issueStart)
    begin
      expIdx_reg <= wb_dat_i[5:0];
      autoSlot_reg <= wb_dat_i[ISS_AUTO_BIT];
    end
  end

  // Data-present is a driver setting handed on to the data path
  // The block does not check it against the response type
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      dataPresent <= 1'b0;
    else
      dataPresent <= ctl_reg[CTL_DATA_BIT];
  end

  // Receiver state
  src_state_e state_reg;
  src_state_e state_next;
  logic [135:0] shift_reg;
  logic [7:0] cnt_reg;
  logic [7:0] len_reg;
  logic [6:0] crc_reg;

  // Frame kind from the response type field
  wire logic isLong = rspType == RSP_L136;
  wire logic withBusy = rspType == RSP_L48B;
  wire logic armReq = issueStart & (rspType != RSP_NONE);

  // Sequencer events, all qualified by a sampled clock rise
  // The last bit is the end bit; the frame is complete at that rise
  wire logic startSeen = (state_reg == WAITSTART) & sdRise & ~cmdBit;
  wire logic bitIn = (state_reg == SHIFT) & sdRise;
  wire logic lastBit = (cnt_reg == len_reg - 8'h01) & sdRise;
  wire logic doneEv = bitIn & lastBit;
  wire logic busyEnd = (state_reg == BUSY) & sdRise & dat0Bit;

  // Next state; an issue write with no response leaves it idle
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      IDLE:
        if (armReq)
          state_next = WAITSTART;
      WAITSTART:
        if (startSeen)
          state_next = SHIFT;
      SHIFT:
        if (doneEv)
          state_next = withBusy ? BUSY : IDLE;
      BUSY:
        if (busyEnd)
          state_next = IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      state_reg <= IDLE;
    else
      state_reg <= state_next;
  end

  // Frame length, fixed when the receiver is armed
  // Length picks which rise carries the end bit
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      len_reg <= LEN_SHORT;
    else if (state_reg == IDLE && armReq)
      len_reg <= isLong ? LEN_LONG : LEN_SHORT;
  end

  // Bit counter; the start bit counts as bit one
  // It stops with the receiver and reloads at each start bit
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      cnt_reg <= 8'h00;
    else if (startSeen)
      cnt_reg <= 8'h01;
    else if (bitIn)
      cnt_reg <= cnt_reg + 8'h01;
  end

  // Frame shifter, first bit ends up on top
  // The whole frame is kept; the store takes its slice at the end bit
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      shift_reg <= '0;
    else if (startSeen)
      shift_reg <= '0;
    else if (bitIn)
      shift_reg <= longRsp;
  end

  // CRC7 update for one received bit
  wire logic crcFb = crc_reg[6] ^ cmdBit;
  wire logic [6:0] crc_next = {crc_reg[5:3], crc_reg[2] ^ crcFb,
    crc_reg[1:0], crcFb};
  // Long frames leave the header byte out, all frames the CRC and end bit
  wire logic crcCover = isLong ? (cnt_reg >= CRC_HEAD_SKIP) : 1'b1;
  wire logic crcStep = bitIn & crcCover &
    (cnt_reg < len_reg - CRC_TAIL_SKIP);

  // CRC register, cleared at the start bit
  // The start bit is zero, so a cleared register absorbs it unchanged
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      crc_reg <= 7'h00;
    else if (startSeen)
      crc_reg <= 7'h00;
    else if (crcStep)
      crc_reg <= crc_next;
  end

  // Frame as it stands once the current bit is shifted in
  wire logic [47:0] shortRsp = {shift_reg[46:0], cmdBit};
  wire logic [135:0] longRsp = {shift_reg[134:0], cmdBit};
  // Received CRC sits in bits 7:1 of either frame
  wire logic [6:0] rxCrc = shortRsp[7:1];
  // Checks, each only when its enable bit is set
  wire logic idxBad = ctl_reg[CTL_IDXCHK_BIT] & ~isLong &
    (shortRsp[45:40] != expIdx_reg);
  wire logic crcBad = ctl_reg[CTL_CRCCHK_BIT] & (crc_reg != rxCrc);

  // Busy flag; high from the end bit until DAT0 returns high
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      busyActive <= 1'b0;
    else
      busyActive <= state_reg == BUSY;
  end

  // Response store: only the addressed slice is written, the rest
  // keeps its value so an auto response survives a plain short one
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      store_reg <= '0;
    else if (doneEv)
    begin
      if (isLong)
        store_reg[119:0] <= longRsp[127:8];
      else if (autoSlot_reg)
        store_reg[127:96] <= shortRsp[39:8];
      else
        store_reg[31:0] <= shortRsp[39:8];
    end
  end

  // Status events; auto slot errors go to their own bit
  // Busy end marks DAT0 released after a busy-type response
  wire logic [ST_W-1:0] evSet;
  assign evSet[ST_IDX] = doneEv & idxBad & ~autoSlot_reg;
  assign evSet[ST_CRC] = doneEv & crcBad & ~autoSlot_reg;
  assign evSet[ST_DONE] = doneEv;
  assign evSet[ST_BUSYEND] = busyEnd;
  assign evSet[ST_AUTOERR] = doneEv & autoSlot_reg & (idxBad | crcBad);
  // A status read clears all bits
  wire logic statRd = rdReq & hitStat;

  // Sticky status; an event in the clearing cycle is kept
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      stat_reg <= '0;
    else
      stat_reg <= (statRd ? '0 : stat_reg) | evSet;
  end

  // Interrupt level, one cycle behind the status
  // Masked bits stay set in status but never raise the line
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      irq <= 1'b0;
    else
      irq <= |(stat_reg & mask_reg);
  end
endmodule
`default_nettype wire

// ===== design/src_pkg.sv
// Package: register map, field layout and response constants for capture
package src_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CMD_CTRL = 8'h0C;
  localparam logic [7:0] OFF_RESP0 = 8'h10;
  localparam logic [7:0] OFF_RESP1 = 8'h14;
  localparam logic [7:0] OFF_RESP2 = 8'h18;
  localparam logic [7:0] OFF_RESP3 = 8'h1C;
  localparam logic [7:0] OFF_ERR_STAT = 8'h30;
  localparam logic [7:0] OFF_ERR_MASK = 8'h34;
  localparam logic [7:0] OFF_ISSUE = 8'h38;
  // Command control field positions
  localparam int CTL_DATA_BIT = 5;
  localparam int CTL_IDXCHK_BIT = 4;
  localparam int CTL_CRCCHK_BIT = 3;
  localparam int CTL_RSVD_BIT = 2;
  localparam logic [15:0] CTL_WRITE_MASK = 16'hFF_FB;
  localparam logic [15:0] CTL_RESET = 16'h0000;
  // Response type encodings
  localparam logic [1:0] RSP_NONE = 2'h0;
  localparam logic [1:0] RSP_L136 = 2'h1;
  localparam logic [1:0] RSP_L48 = 2'h2;
  localparam logic [1:0] RSP_L48B = 2'h3;
  // Response lengths in bits
  localparam logic [7:0] LEN_SHORT = 8'h30;
  localparam logic [7:0] LEN_LONG = 8'h88;
  // Status bits
  localparam int ST_IDX = 0;
  localparam int ST_CRC = 1;
  localparam int ST_DONE = 2;
  localparam int ST_BUSYEND = 3;
  localparam int ST_AUTOERR = 4;
  localparam int ST_W = 5;
  // Issue register fields: [5:0] index, [8] auto command slot
  localparam int ISS_AUTO_BIT = 8;
  // Idle levels of the link pins: DAT0, CMD pulled up, clock low
  localparam logic [2:0] PIN_IDLE = 3'b110;
  // Bits outside the CRC: long header byte, CRC field plus end bit
  localparam logic [7:0] CRC_HEAD_SKIP = 8'h08;
  localparam logic [7:0] CRC_TAIL_SKIP = 8'h08;
endpackage

// ===== verification/src_capture_chk.sv
// Checker for bus handshake, control copy, busy hold and interrupt mask
`timescale 1ns/10ps
`default_nettype none
module src_capture_chk
  import src_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Link and outputs
  input wire logic sdDat0In,
  input wire logic dataPresent,
  input wire logic busyActive,
  input wire logic irq
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // Read and low-lane write answers
  wire logic rdA = wb_ack_o && !wb_we_i;
  wire logic wrA = wb_ack_o && wb_we_i && wb_sel_i[0];
  ack_resp_a: assert property (wb_cyc_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  ack_need_a: assert property (wb_ack_o |-> wb_cyc_i)
    else $error("ack without request");
  unmapped_zero_a: assert property
    (rdA && wb_adr_i == 8'h20 |-> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  rsvd_zero_a: assert property
    (rdA && wb_adr_i == OFF_CMD_CTRL |-> !wb_dat_o[CTL_RSVD_BIT])
    else $error("reserved bit set");
  data_copy_a: assert property (wrA && wb_adr_i == OFF_CMD_CTRL |->
    ##2 dataPresent == $past(wb_dat_i[CTL_DATA_BIT], 2))
    else $error("data present wrong");
  busy_hold_a: assert property
    ((!sdDat0In) [*6] ##0 busyActive |=> busyActive)
    else $error("busy ended while low");
  irq_mask_a: assert property (wrA && wb_adr_i == OFF_ERR_MASK &&
    wb_dat_i[ST_W-1:0] == 5'h00 |-> ##3 !irq)
    else $error("masked irq high");
endmodule
bind src_capture src_capture_chk src_capture_chk_inst (.clk_sys, .rst,
  .wb_cyc_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
  .wb_ack_o, .sdDat0In, .dataPresent, .busyActive, .irq);
`default_nettype wire

// ===== verification/src_card_model.sv
// Card model: sends response frames on the command line, busy on DAT0
`timescale 1ns/10ps
`default_nettype none
module src_card_model
(
  // Link lines
  output logic sdClk,
  output logic sdCmdIn,
  output logic sdDat0In
);
  // Idle: clock still, pulled-up lines high
  initial
  begin
    sdClk = 1'b0;
    sdCmdIn = 1'b1;
    sdDat0In = 1'b1;
  end
  // Send n bits MSB first, then hold DAT0 low for b-1 clocks and release it on clock b
  task automatic send(input logic [135:0] f, input int n, input int b);
    for (int i = n - 1; i >= -b; i--)
    begin
      sdCmdIn = (i >= 0) ? f[i] : 1'b1;
      sdDat0In = (i >= 0) || (i == -b);
      #32 sdClk = 1'b1;
      #32 sdClk = 1'b0;
    end
    sdDat0In = 1'b1;
  endtask
endmodule
`default_nettype wire

// ===== verification/testbench.sv
// Bench: register access, response capture, checks and interrupt
`timescale 1ns/10ps
`default_nettype none
module testbench
  import src_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o, rd, pl, q;
  logic wb_ack_o, sdClk, sdCmdIn, sdDat0In, dataPresent, busyActive, irq;
  logic [127:0] lp;
  logic [5:0] x;
  int e;
  int err_total = 0;
  int samples_checked = 0;
  src_capture src_capture_inst (.clk_sys, .rst, .wb_cyc_i,
    .wb_stb_i(wb_cyc_i), .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .sdClk, .sdCmdIn, .sdDat0In, .dataPresent,
    .busyActive, .irq);
  src_card_model src_card_model_inst (.sdClk, .sdCmdIn, .sdDat0In);
  // System clock
  initial
  begin
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [31:0] ex, input logic [31:0] got);
    samples_checked++;
    if (got !== ex)
    begin
      err_total++;
      $display("[FAIL] %0t exp %h got %h", $time, ex, got);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // One classic bus cycle, held until the ack edge
  task automatic wb(input logic w, input logic [7:0] a,
    input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    @(posedge clk_sys);
    while (wb_ack_o !== 1'b1)
      @(posedge clk_sys);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] ex);
    wb(1'b0, a, 32'h0000_0000, 4'hF);
    chk(ex, rd);
  endtask
  function automatic logic [6:0] crc7(input logic [127:0] d, input int n);
    logic [6:0] c;
    c = 7'h00;
    for (int i = n - 1; i >= 0; i--)
      c = {c[5:0], 1'b0} ^ ((c[6] ^ d[i]) ? 7'h09 : 7'h00);
    return c;
  endfunction
  // Arm the receiver, let the card answer, look at busy 40 system clocks after the frame
  task automatic rsp(input logic [15:0] k, input logic [8:0] s,
    input logic [5:0] ix, input logic bad, input logic [119:0] p,
    input int b);
    logic [127:0] m;
    int n;
    n = (k[1:0] == RSP_L136) ? 136 : 48;
    m = (n > 48) ? {8'h3F, p} : {2'b00, ix, p[31:0]};
    wb(1'b1, OFF_CMD_CTRL, {16'h0000, k}, 4'hF);
    wb(1'b1, OFF_ISSUE, {23'h0, s}, 4'hF);
    fork
      src_card_model_inst.send({m, crc7(m, (n > 48) ? 120 : 40) ^ 7'(bad),
        1'b1}, n, b);
      begin
        repeat (n * 8 + 40) @(posedge clk_sys);
        chk(b > 0, busyActive);
      end
    join
    repeat (10) @(posedge clk_sys);
  endtask
  // Watchdog
  initial
  begin
    #300000;
    err_total++;
    finish_test;
  end
  initial
  begin
    void'($urandom(18));
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    wb(1'b1, OFF_CMD_CTRL, 32'h0000_FFFF, 4'h1);
    rdc(OFF_CMD_CTRL, 32'h0000_00FB);
    chk(1'b1, dataPresent);
    rdc(8'h20, 32'h0000_0000);
    for (int k = 0; k < 8; k++)
    begin
      e = k % 4;
      x = $urandom;
      pl = $urandom;
      wb(1'b1, OFF_ERR_MASK, (k < 4) ? 32'h0000_0003 : 32'h0000_0000, 4'h1);
      rsp({10'h000, 1'($urandom), e != 3, e != 3, 1'b0, RSP_L48},
        x ^ 6'(e == 1), x, e > 1, {88'h0, pl}, 0);
      chk((e == 1 || e == 2) && k < 4, irq);
      rdc(OFF_ERR_STAT, {29'h0, 1'b1, e == 2, e == 1});
      rdc(OFF_RESP0, pl);
      $display("test %0d done", k);
    end
    wb(1'b1, OFF_RESP0, 32'hFFFF_FFFF, 4'hF);
    q = $urandom;
    rsp(16'h001A, {3'b100, x}, x, 1'b0, {88'h0, q}, 0);
    rdc(OFF_RESP3, q);
    rdc(OFF_RESP0, pl);
    rsp(16'h001A, {3'b100, ~x}, x, 1'b0, {88'h0, q}, 0);
    rdc(OFF_ERR_STAT, 32'h0000_0014);
    lp = {$urandom, $urandom, $urandom, $urandom};
    rsp(16'h0009, 9'h000, x, 1'b0, lp[119:0], 0);
    for (int i = 0; i < 4; i++)
      rdc(OFF_RESP0 + 8'(4 * i), (i < 3) ? lp[32 * i +: 32] :
        {q[31:24], lp[119:96]});
    rsp(16'h001B, {3'b000, x}, x, 1'b0, lp[119:0], 20);
    rsp(16'h0000, {3'b000, x}, x, 1'b0, ~lp[119:0], 0);
    rdc(OFF_ERR_STAT, 32'h0000_000C);
    rdc(OFF_RESP0, lp[31:0]);
    $display("tests done");
    finish_test;
  end
endmodule
`default_nettype wire
